/* design/vsp_cfg.svh */
`ifndef VSP_CFG_SVH
`define VSP_CFG_SVH

// ==========================================================
// Bus geometry
`define VSP_AW 8
`define VSP_DW 16

// ==========================================================
// Register offsets
`define VSP_ADDR_OPERATION 8'h00
`define VSP_ADDR_ON_OFF 8'h01
`define VSP_ADDR_VOUT_CMD 8'h02
`define VSP_ADDR_VOUT_TRIM 8'h03
`define VSP_ADDR_VOUT_MAX 8'h04
`define VSP_ADDR_MARGIN_HI 8'h05
`define VSP_ADDR_MARGIN_LO 8'h06
`define VSP_ADDR_OV_LIMIT 8'h07
`define VSP_ADDR_OV_RESP 8'h08
`define VSP_ADDR_OVUV_CFG 8'h09
`define VSP_ADDR_LOOP_GAIN 8'h0a
`define VSP_ADDR_LOOP_RESID 8'h0b
`define VSP_ADDR_STATUS 8'h0c
`define VSP_ADDR_CLEAR 8'h0d
`define VSP_ADDR_TARGET 8'h0e
`define VSP_ADDR_CEILING 8'h0f

// ==========================================================
// Field positions
`define VSP_OP_ON_BIT 7
`define VSP_OP_MHI_BIT 5
`define VSP_OP_MLO_BIT 4
`define VSP_OOC_POL_BIT 0
`define VSP_OOC_PIN_BIT 1
`define VSP_OOC_CMD_BIT 2
`define VSP_OVR_HICCUP_BIT 0
`define VSP_OVUV_SHARE_BIT 0
`define VSP_ST_ON_BIT 0
`define VSP_ST_OV_BIT 1
`define VSP_ST_INIT_BIT 2
`define VSP_ST_MARGIN_BIT 3
`define VSP_ST_HICCUP_BIT 4
`define VSP_ST_STRAPERR_BIT 5
`define VSP_ST_LATCH_BIT 6
`define VSP_GAIN_W 10
`define VSP_RESID_W 7

// ==========================================================
// Reset and factory values
`define VSP_RST_POL 1'b1
`define VSP_RST_USE_PIN 1'b1
`define VSP_RST_USE_CMD 1'b0
`define VSP_RST_HICCUP 1'b1
`define VSP_RST_SHARE 1'b0
`define VSP_RST_GAIN 10'h0c8
`define VSP_RST_RESID 7'h5a
`define VSP_MARGIN_UP_PCT 8'd105
`define VSP_MARGIN_DN_PCT 8'd95
`define VSP_OV_PCT 8'd115
`define VSP_CEIL_PCT 8'd115
`define VSP_PCT_BASE 24'd100
`define VSP_SETTLE_CNT 2'h3

// ==========================================================
// Timing
`define VSP_CLK_MHZ 50
`define VSP_HICCUP_US 200

`endif

/* design/vsp_ctrl.sv */
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "vsp_cfg.svh"
module vsp_ctrl #(
   parameter int unsigned HICCUP_CYC = `VSP_HICCUP_US * `VSP_CLK_MHZ
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire vsp_pkg::vsp_req_t bus_req,
   output logic [`VSP_DW-1:0] bus_rdata,
   input wire logic ctrl_pin_level,
   input wire logic ctrl_pin_driven,
   input wire logic pwm_clk_pin,
   input wire logic [4:0] setpoint_strap_pin,
   input wire logic nvm_vout_valid,
   input wire logic [15:0] nvm_vout,
   input wire logic [15:0] vout_meas,
   input wire logic [15:0] iout_meas,
   output logic out_enable,
   output logic [15:0] vout_target,
   output vsp_pkg::vsp_loop_t loop_cfg,
   output logic [15:0] iout_sample,
   output logic pwm_update,
   output logic ov_fault
);
   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic pwm_prev;
      logic [4:0] strap_s1;
      logic [4:0] strap_s2;
      logic [1:0] settle;
      vsp_pkg::vsp_state_t st;
      logic [15:0] strap_nom;
      logic strap_err;
      logic [15:0] vout_cmd;
      logic [15:0] trim;
      logic [15:0] vmax;
      logic [15:0] mhi;
      logic [15:0] mlo;
      logic [15:0] ovlim;
      logic ov_hiccup;
      logic share;
      logic op_on;
      logic op_mhi;
      logic op_mlo;
      logic pol;
      logic use_pin;
      logic use_cmd;
      vsp_pkg::vsp_loop_t loop;
      logic fault_latched;
      logic fault_hiccup;
      logic [23:0] hic_cnt;
      logic ov_sticky;
      logic out_en;
      logic [15:0] target;
      logic [15:0] iout;
      logic pwm_upd;
      logic [`VSP_DW-1:0] rdata;
   } vsp_state_reg_t;

   localparam logic [23:0] HICCUP_LOAD = 24'(HICCUP_CYC - 1);

   vsp_state_reg_t s_r;
   vsp_state_reg_t s_nxt;
   logic [15:0] hw_ceil;
   logic [15:0] calc_target;
   logic [16:0] strap_dec;
   logic lvl_eff;
   logic pin_act;
   logic en_req;
   logic ov_evt;
   logic latch_mode;
   logic clear_wr;
   logic pwm_rise;
   logic [`VSP_DW-1:0] status;

   // ==========================================================
   // Setpoint arithmetic
   assign hw_ceil = vsp_pkg::vsp_pct(s_r.strap_nom, `VSP_CEIL_PCT);
   assign strap_dec = vsp_pkg::vsp_strap_mv(s_r.strap_s2);

   vsp_target_calc u_calc (
      .vout_cmd(s_r.vout_cmd),
      .margin_hi(s_r.mhi),
      .margin_lo(s_r.mlo),
      .sel_hi(s_r.op_mhi),
      .sel_lo(s_r.op_mlo),
      .trim(s_r.trim),
      .vout_max(s_r.vmax),
      .hw_ceil(hw_ceil),
      .target(calc_target)
   );

   // ==========================================================
   // Enable and fault decode
   always_comb begin
      lvl_eff = s_r.sync2[1] ? s_r.sync2[2] : 1'b1;
      pin_act = s_r.pol ? lvl_eff : !lvl_eff;
      en_req = (s_r.use_pin & pin_act) | (s_r.use_cmd & s_r.op_on);
      ov_evt = s_r.out_en & (vout_meas > s_r.ovlim);
      latch_mode = s_r.share | !s_r.ov_hiccup;
      clear_wr = (s_r.st == vsp_pkg::VSP_RUN) & bus_req.we & (bus_req.addr == `VSP_ADDR_CLEAR);
      pwm_rise = s_r.sync2[0] & !s_r.pwm_prev;
      status = '0;
      status[`VSP_ST_ON_BIT] = s_r.out_en;
      status[`VSP_ST_OV_BIT] = s_r.ov_sticky;
      status[`VSP_ST_INIT_BIT] = (s_r.st == vsp_pkg::VSP_RUN);
      status[`VSP_ST_MARGIN_BIT] = s_r.op_mhi | s_r.op_mlo;
      status[`VSP_ST_HICCUP_BIT] = s_r.fault_hiccup;
      status[`VSP_ST_STRAPERR_BIT] = s_r.strap_err;
      status[`VSP_ST_LATCH_BIT] = s_r.fault_latched;
   end

   // ==========================================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      // Pins cross two flops before anything looks at them
      s_nxt.sync1 = {ctrl_pin_level, ctrl_pin_driven, pwm_clk_pin};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.pwm_prev = s_r.sync2[0];
      s_nxt.strap_s1 = setpoint_strap_pin;
      s_nxt.strap_s2 = s_r.strap_s1;
      s_nxt.pwm_upd = 1'b0;
      s_nxt.rdata = '0;
      s_nxt.target = calc_target;
      case (s_r.st)
         vsp_pkg::VSP_SETTLE: begin
            // Let the strap synchroniser fill before sampling
            s_nxt.settle = s_r.settle + 2'h1;
            if (s_r.settle == `VSP_SETTLE_CNT) begin
               s_nxt.st = vsp_pkg::VSP_STRAP;
            end
         end
         vsp_pkg::VSP_STRAP: begin
            s_nxt.strap_nom = strap_dec[15:0];
            s_nxt.strap_err = strap_dec[16];
            s_nxt.vout_cmd = strap_dec[15:0];
            s_nxt.st = vsp_pkg::VSP_FACTORY;
         end
         vsp_pkg::VSP_FACTORY: begin
            s_nxt.mhi = vsp_pkg::vsp_pct(s_r.strap_nom, `VSP_MARGIN_UP_PCT);
            s_nxt.mlo = vsp_pkg::vsp_pct(s_r.strap_nom, `VSP_MARGIN_DN_PCT);
            s_nxt.ovlim = vsp_pkg::vsp_pct(s_r.strap_nom, `VSP_OV_PCT);
            s_nxt.vmax = hw_ceil;
            s_nxt.st = vsp_pkg::VSP_USER;
         end
         vsp_pkg::VSP_USER: begin
            if (nvm_vout_valid) begin
               s_nxt.vout_cmd = nvm_vout;
            end
            s_nxt.st = vsp_pkg::VSP_RUN;
         end
         vsp_pkg::VSP_RUN: begin
            // Register writes
            if (bus_req.we) begin
               case (bus_req.addr)
                  `VSP_ADDR_OPERATION: begin
                     s_nxt.op_on = bus_req.wdata[`VSP_OP_ON_BIT];
                     s_nxt.op_mhi = bus_req.wdata[`VSP_OP_MHI_BIT];
                     s_nxt.op_mlo = bus_req.wdata[`VSP_OP_MLO_BIT];
                  end
                  `VSP_ADDR_ON_OFF: begin
                     s_nxt.pol = bus_req.wdata[`VSP_OOC_POL_BIT];
                     s_nxt.use_pin = bus_req.wdata[`VSP_OOC_PIN_BIT];
                     s_nxt.use_cmd = bus_req.wdata[`VSP_OOC_CMD_BIT];
                  end
                  `VSP_ADDR_VOUT_CMD: s_nxt.vout_cmd = bus_req.wdata;
                  `VSP_ADDR_VOUT_TRIM: s_nxt.trim = bus_req.wdata;
                  `VSP_ADDR_VOUT_MAX: begin
                     s_nxt.vmax = (bus_req.wdata > hw_ceil) ? hw_ceil : bus_req.wdata;
                  end
                  `VSP_ADDR_MARGIN_HI: s_nxt.mhi = bus_req.wdata;
                  `VSP_ADDR_MARGIN_LO: s_nxt.mlo = bus_req.wdata;
                  `VSP_ADDR_OV_LIMIT: s_nxt.ovlim = bus_req.wdata;
                  `VSP_ADDR_OV_RESP: s_nxt.ov_hiccup = bus_req.wdata[`VSP_OVR_HICCUP_BIT];
                  `VSP_ADDR_OVUV_CFG: s_nxt.share = bus_req.wdata[`VSP_OVUV_SHARE_BIT];
                  `VSP_ADDR_LOOP_GAIN: s_nxt.loop.gain = bus_req.wdata[`VSP_GAIN_W-1:0];
                  `VSP_ADDR_LOOP_RESID: begin
                     s_nxt.loop.resid = bus_req.wdata[`VSP_RESID_W-1:0];
                  end
                  default: begin
                  end
               endcase
            end
            // Over-voltage response; a new event beats a clear
            if (ov_evt) begin
               s_nxt.ov_sticky = 1'b1;
               if (latch_mode) begin
                  s_nxt.fault_latched = 1'b1;
               end else begin
                  s_nxt.fault_hiccup = 1'b1;
                  s_nxt.hic_cnt = HICCUP_LOAD;
               end
            end else begin
               if (clear_wr) begin
                  s_nxt.ov_sticky = 1'b0;
               end
               if (clear_wr || !en_req) begin
                  s_nxt.fault_latched = 1'b0;
               end
               if (s_r.fault_hiccup) begin
                  if (s_r.hic_cnt != 24'h000000) begin
                     s_nxt.hic_cnt = s_r.hic_cnt - 24'h000001;
                  end else begin
                     s_nxt.fault_hiccup = 1'b0;
                  end
               end
            end
            s_nxt.out_en = en_req & !s_nxt.fault_latched & !s_nxt.fault_hiccup;
            // Current sample taken on each rising edge of the switching clock
            if (pwm_rise) begin
               s_nxt.iout = iout_meas;
               s_nxt.pwm_upd = 1'b1;
            end
         end
         default: s_nxt.st = vsp_pkg::VSP_SETTLE;
      endcase
      // Reads answer in the next cycle only
      if (bus_req.re) begin
         case (bus_req.addr)
            `VSP_ADDR_OPERATION: begin
               s_nxt.rdata[`VSP_OP_ON_BIT] = s_r.op_on;
               s_nxt.rdata[`VSP_OP_MHI_BIT] = s_r.op_mhi;
               s_nxt.rdata[`VSP_OP_MLO_BIT] = s_r.op_mlo;
            end
            `VSP_ADDR_ON_OFF: begin
               s_nxt.rdata[`VSP_OOC_POL_BIT] = s_r.pol;
               s_nxt.rdata[`VSP_OOC_PIN_BIT] = s_r.use_pin;
               s_nxt.rdata[`VSP_OOC_CMD_BIT] = s_r.use_cmd;
            end
            `VSP_ADDR_VOUT_CMD: s_nxt.rdata = s_r.vout_cmd;
            `VSP_ADDR_VOUT_TRIM: s_nxt.rdata = s_r.trim;
            `VSP_ADDR_VOUT_MAX: s_nxt.rdata = s_r.vmax;
            `VSP_ADDR_MARGIN_HI: s_nxt.rdata = s_r.mhi;
            `VSP_ADDR_MARGIN_LO: s_nxt.rdata = s_r.mlo;
            `VSP_ADDR_OV_LIMIT: s_nxt.rdata = s_r.ovlim;
            `VSP_ADDR_OV_RESP: s_nxt.rdata[`VSP_OVR_HICCUP_BIT] = s_r.ov_hiccup;
            `VSP_ADDR_OVUV_CFG: s_nxt.rdata[`VSP_OVUV_SHARE_BIT] = s_r.share;
            `VSP_ADDR_LOOP_GAIN: s_nxt.rdata[`VSP_GAIN_W-1:0] = s_r.loop.gain;
            `VSP_ADDR_LOOP_RESID: s_nxt.rdata[`VSP_RESID_W-1:0] = s_r.loop.resid;
            `VSP_ADDR_STATUS: s_nxt.rdata = status;
            `VSP_ADDR_TARGET: s_nxt.rdata = s_r.target;
            `VSP_ADDR_CEILING: s_nxt.rdata = hw_ceil;
            default: s_nxt.rdata = '0;
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_r <= '0;
         s_r.st <= vsp_pkg::VSP_SETTLE;
         s_r.pol <= `VSP_RST_POL;
         s_r.use_pin <= `VSP_RST_USE_PIN;
         s_r.use_cmd <= `VSP_RST_USE_CMD;
         s_r.ov_hiccup <= `VSP_RST_HICCUP;
         s_r.share <= `VSP_RST_SHARE;
         s_r.loop.gain <= `VSP_RST_GAIN;
         s_r.loop.resid <= `VSP_RST_RESID;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus_rdata = s_r.rdata;
   assign out_enable = s_r.out_en;
   assign vout_target = s_r.target;
   assign loop_cfg = s_r.loop;
   assign iout_sample = s_r.iout;
   assign pwm_update = s_r.pwm_upd;
   assign ov_fault = s_r.ov_sticky;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_strap_frozen: assert property (
      (s_r.st == vsp_pkg::VSP_RUN) && $past(s_r.st == vsp_pkg::VSP_RUN) |-> $stable(s_r.strap_nom))
      else $error("strap nominal changed while running");
   a_ceiling_clamp: assert property (
      (s_r.st == vsp_pkg::VSP_RUN) |-> ##1 (vout_target <= $past(hw_ceil)))
      else $error("target above hardware ceiling");
   a_vmax_lowers: assert property (
      (s_r.st == vsp_pkg::VSP_RUN) |-> (s_r.vmax <= hw_ceil))
      else $error("output maximum above ceiling");
   a_ov_shutdown: assert property (
      ov_evt |=> !out_enable)
      else $error("output still on after over-voltage");
   a_share_latch: assert property (
      ov_evt && s_r.share |=> s_r.fault_latched && !s_r.fault_hiccup)
      else $error("shared mode did not latch off");
   a_hiccup_retry: assert property (
      s_r.fault_hiccup && (s_r.hic_cnt == 24'h000000) && !ov_evt |=> !s_r.fault_hiccup)
      else $error("hiccup did not retry");
   a_cmd_readback: assert property (
      (s_r.st == vsp_pkg::VSP_RUN) && bus_req.we && (bus_req.addr == `VSP_ADDR_VOUT_CMD)
      ##1 bus_req.re && (bus_req.addr == `VSP_ADDR_VOUT_CMD) && !bus_req.we
      |=> bus_rdata == $past(bus_req.wdata, 2))
      else $error("command readback differs");
   a_pwm_sample: assert property (
      (s_r.st == vsp_pkg::VSP_RUN) && pwm_rise |=> pwm_update && iout_sample == $past(iout_meas))
      else $error("current not sampled on switching edge");
   a_open_pin_on: assert property (
      (s_r.st == vsp_pkg::VSP_RUN) && !s_r.sync2[1] && s_r.pol && s_r.use_pin
      && !s_r.fault_latched && !s_r.fault_hiccup && !ov_evt |=> out_enable)
      else $error("open control pin not treated as high");

endmodule // vsp_ctrl

/* design/vsp_pkg.sv */
package vsp_pkg;
`include "vsp_cfg.svh"

   typedef enum logic [2:0] {
      VSP_SETTLE,
      VSP_STRAP,
      VSP_FACTORY,
      VSP_USER,
      VSP_RUN
   } vsp_state_t;

   typedef struct packed {
      logic [`VSP_AW-1:0] addr;
      logic [`VSP_DW-1:0] wdata;
      logic we;
      logic re;
   } vsp_req_t;

   typedef struct packed {
      logic [`VSP_GAIN_W-1:0] gain;
      logic [`VSP_RESID_W-1:0] resid;
   } vsp_loop_t;

   // Percentage of a millivolt value, truncated
   function automatic logic [15:0] vsp_pct(input logic [15:0] v, input logic [7:0] p);
      logic [23:0] prod;
      prod = {8'h00, v} * {16'h0000, p};
      return 16'(prod / `VSP_PCT_BASE);
   endfunction

   // Strap code to millivolts; bit 16 flags a code outside the table
   function automatic logic [16:0] vsp_strap_mv(input logic [4:0] code);
      logic [16:0] r;
      r = {1'b0, 16'h0258};
      case (code)
         5'h00: r = {1'b0, 16'h03e8};
         5'h01: r = {1'b0, 16'h0258};
         5'h02: r = {1'b0, 16'h028a};
         5'h03: r = {1'b0, 16'h02bc};
         5'h04: r = {1'b0, 16'h02ee};
         5'h05: r = {1'b0, 16'h0320};
         5'h06: r = {1'b0, 16'h0352};
         5'h07: r = {1'b0, 16'h0384};
         5'h08: r = {1'b0, 16'h03b6};
         5'h09: r = {1'b0, 16'h03e8};
         5'h0a: r = {1'b0, 16'h041a};
         5'h0b: r = {1'b0, 16'h044c};
         5'h0c: r = {1'b0, 16'h047e};
         5'h0d: r = {1'b0, 16'h04b0};
         5'h0e: r = {1'b0, 16'h04e2};
         5'h0f: r = {1'b0, 16'h0514};
         5'h10: r = {1'b0, 16'h0578};
         5'h11: r = {1'b0, 16'h05dc};
         5'h12: r = {1'b0, 16'h0640};
         5'h13: r = {1'b0, 16'h06a4};
         5'h14: r = {1'b0, 16'h0708};
         5'h1f: r = {1'b0, 16'h04b0};
         default: r = {1'b1, 16'h0258};
      endcase
      return r;
   endfunction

endpackage

/* design/vsp_target_calc.sv */
`timescale 1ns/1ps
// ==========================================================
// Regulated target: nominal or margin level, plus trim, clamped
module vsp_target_calc (
   input wire logic [15:0] vout_cmd,
   input wire logic [15:0] margin_hi,
   input wire logic [15:0] margin_lo,
   input wire logic sel_hi,
   input wire logic sel_lo,
   input wire logic signed [15:0] trim,
   input wire logic [15:0] vout_max,
   input wire logic [15:0] hw_ceil,
   output logic [15:0] target
);
   logic [15:0] nominal;
   logic [15:0] ceiling;
   logic signed [17:0] sum;

   always_comb begin
      // High wins when software sets both margin bits
      if (sel_hi) begin
         nominal = margin_hi;
      end else if (sel_lo) begin
         nominal = margin_lo;
      end else begin
         nominal = vout_cmd;
      end
      sum = $signed({2'b00, nominal}) + 18'(trim);
      ceiling = (vout_max < hw_ceil) ? vout_max : hw_ceil;
      if (sum < 18'sd0) begin
         target = 16'h0000;
      end else if (sum > $signed({2'b00, ceiling})) begin
         target = ceiling;
      end else begin
         target = sum[15:0];
      end
   end
endmodule // vsp_target_calc

/* tb/vout_setpoint_enable_ovp_ctrl_tb.sv */
`timescale 1ns/1ps
`include "vsp_cfg.svh"
module vout_setpoint_enable_ovp_ctrl_tb;
   localparam int HC = 20;
   localparam logic [4:0] SC [5] = '{5'h00, 5'h01, 5'h14, 5'h1f, 5'h15};
   localparam logic [15:0] SV [5] = '{16'h03e8, 16'h0258, 16'h0708, 16'h04b0, 16'h0258};
   localparam logic [7:0] DA [9] = '{8'h01, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h05, 8'h06, 8'h07, 8'h04};
   localparam logic [15:0] DE [9] = '{16'h0003, 16'h0001, 16'h0000, 16'h00c8, 16'h005a,
      16'h0483, 16'h0415, 16'h04f1, 16'h04f1};
   localparam logic [7:0] TA [14] = '{8'h02, 8'h03, 8'h03, 8'h03, 8'h02, 8'h04, 8'h04,
      8'h02, 8'h00, 8'h03, 8'h00, 8'h03, 8'h05, 8'h00};
   localparam logic [15:0] TD [14] = '{16'h03e8, 16'h0032, 16'hff9c, 16'h0000, 16'h0600,
      16'h0450, 16'h0600, 16'h03e8, 16'h00e0, 16'h0014, 16'h00d0, 16'h0000, 16'h0460, 16'h00e0};
   localparam logic [15:0] TE [14] = '{16'h03e8, 16'h041a, 16'h0384, 16'h03e8, 16'h04f1,
      16'h0450, 16'h04f1, 16'h03e8, 16'h0483, 16'h0497, 16'h0429, 16'h0415, 16'h0415, 16'h0460};
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   vsp_pkg::vsp_req_t req = '0;
   logic pin_drive = 1'b0;
   logic pin_val = 1'b0;
   logic [15:0] bump = 16'h0000;
   logic [4:0] strap = 5'h0b;
   logic nvm_ok = 1'b0;
   logic [15:0] nvm_v = 16'h0400;
   logic [15:0] iout = 16'h0000;
   logic pin_lvl, pin_drv, pwm, en, upd, ovf;
   logic [15:0] rdata, vmeas, vtgt, isamp;
   vsp_pkg::vsp_loop_t lcfg;
   int err_total = 0;
   int compares = 0;

   initial begin
      forever #10 clk = ~clk;
   end

   vsp_ctrl #(.HICCUP_CYC(HC)) dut (.clk(clk), .sys_rst(sys_rst), .bus_req(req),
      .bus_rdata(rdata), .ctrl_pin_level(pin_lvl), .ctrl_pin_driven(pin_drv),
      .pwm_clk_pin(pwm), .setpoint_strap_pin(strap), .nvm_vout_valid(nvm_ok),
      .nvm_vout(nvm_v), .vout_meas(vmeas), .iout_meas(iout), .out_enable(en),
      .vout_target(vtgt), .loop_cfg(lcfg), .iout_sample(isamp), .pwm_update(upd),
      .ov_fault(ovf));

   vsp_far_end far (.clk(clk), .pin_drive(pin_drive), .pin_val(pin_val), .bump(bump),
      .out_enable(en), .vout_target(vtgt), .ctrl_pin_level(pin_lvl),
      .ctrl_pin_driven(pin_drv), .pwm_clk_pin(pwm), .vout_meas(vmeas));

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk);
      req <= '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      req <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
      @(posedge clk);
      req <= '0;
      // Read data stand only in the cycle after the strobe
      #1 check(rdata, exp);
   endtask

   // Write then read with no gap, as the bus allows
   task automatic wr_rd(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk);
      req <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
      @(posedge clk);
      req <= '0;
      #1 check(rdata, d);
   endtask

   task automatic chk_tgt(input logic [15:0] e);
      rd(`VSP_ADDR_TARGET, e);
      check(vtgt, e);
   endtask

   task automatic wait_en(input logic v, input int n);
      #1;
      for (int k = 0; k < n && en !== v; k++) begin
         @(posedge clk);
         #1;
      end
      check({15'h0000, en}, {15'h0000, v});
   endtask

   // Twelve cycles cover the whole init sequence after release
   task automatic boot(input logic [4:0] code, input logic nv);
      @(posedge clk);
      sys_rst <= 1'b1;
      strap <= code;
      nvm_ok <= nv;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (12) @(posedge clk);
   endtask

   task automatic final_report;
      $display("err_total %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      #400us;
      err_total++;
      final_report();
   end

   // ==========================================================
   // Tests
   initial begin
      for (int i = 0; i < 5; i++) begin
         boot(SC[i], 1'b0);
         rd(`VSP_ADDR_VOUT_CMD, SV[i]);
         rd(`VSP_ADDR_CEILING, 16'((32'(SV[i]) * 115) / 100));
         rd(`VSP_ADDR_STATUS, (i == 4) ? 16'h0025 : 16'h0005);
      end
      boot(5'h0b, 1'b1);
      rd(`VSP_ADDR_VOUT_CMD, 16'h0400);
      check(vtgt, 16'h0400);
      for (int i = 0; i < 9; i++) rd(DA[i], DE[i]);
      @(posedge clk) strap <= 5'h14;
      rd(`VSP_ADDR_CEILING, 16'h04f1);
      rd(8'h20, 16'h0000);
      wr(`VSP_ADDR_CEILING, 16'h0000);
      rd(`VSP_ADDR_CEILING, 16'h04f1);
      wr(`VSP_ADDR_LOOP_GAIN, 16'h0258);
      wr(`VSP_ADDR_LOOP_RESID, 16'h0046);
      #1 check({6'h00, lcfg.gain}, 16'h0258);
      check({9'h000, lcfg.resid}, 16'h0046);
      @(posedge clk) pin_drive <= 1'b1;
      wait_en(1'b0, 10);
      wr(`VSP_ADDR_ON_OFF, 16'h0002);
      wait_en(1'b1, 10);
      @(posedge clk) pin_val <= 1'b1;
      wait_en(1'b0, 10);
      wr(`VSP_ADDR_ON_OFF, 16'h0004);
      wr(`VSP_ADDR_OPERATION, 16'h0080);
      wait_en(1'b1, 10);
      // Output is already on before the command writes below
      for (int i = 0; i < 14; i++) begin
         wr(TA[i], TD[i]);
         chk_tgt(TE[i]);
         if (i == 6) begin
            rd(`VSP_ADDR_VOUT_CMD, 16'h0600);
            rd(`VSP_ADDR_VOUT_MAX, 16'h04f1);
            wr_rd(`VSP_ADDR_VOUT_CMD, 16'h0700);
         end
      end
      wr(`VSP_ADDR_MARGIN_LO, 16'h0400);
      rd(`VSP_ADDR_MARGIN_LO, 16'h0400);
      wr(`VSP_ADDR_ON_OFF, 16'h0003);
      @(posedge clk) pin_drive <= 1'b0;
      wr(`VSP_ADDR_OPERATION, 16'h0020);
      chk_tgt(16'h0460);
      wait_en(1'b1, 10);
      wr(`VSP_ADDR_OPERATION, 16'h0000);
      wr(`VSP_ADDR_OV_LIMIT, 16'h03f0);
      @(posedge clk) bump <= 16'h0014;
      wait_en(1'b0, 10);
      check({15'h0000, ovf}, 16'h0001);
      rd(`VSP_ADDR_STATUS, 16'h0016);
      @(posedge clk) bump <= 16'h0000;
      wait_en(1'b1, 2 * HC + 20);
      wr(`VSP_ADDR_OV_RESP, 16'h0000);
      wr(`VSP_ADDR_CLEAR, 16'h0000);
      @(posedge clk) bump <= 16'h0014;
      wait_en(1'b0, 10);
      @(posedge clk) bump <= 16'h0000;
      repeat (3 * HC) @(posedge clk);
      wait_en(1'b0, 1);
      wr(`VSP_ADDR_CLEAR, 16'h0000);
      wait_en(1'b1, 10);
      wr(`VSP_ADDR_OV_RESP, 16'h0001);
      wr(`VSP_ADDR_OVUV_CFG, 16'h0001);
      @(posedge clk) bump <= 16'h0014;
      wait_en(1'b0, 10);
      @(posedge clk) bump <= 16'h0000;
      repeat (3 * HC) @(posedge clk);
      wait_en(1'b0, 1);
      rd(`VSP_ADDR_STATUS, 16'h0046);
      @(posedge clk) pin_drive <= 1'b1;
      pin_val <= 1'b0;
      repeat (6) @(posedge clk);
      pin_drive <= 1'b0;
      wait_en(1'b1, 20);
      @(posedge clk) iout <= 16'h1234;
      repeat (2) @(posedge clk);
      for (int k = 0; k < 30 && upd !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      check({15'h0000, upd}, 16'h0001);
      repeat (2) @(posedge clk);
      #1 check(isamp, 16'h1234);
      final_report();
   end
endmodule // vout_setpoint_enable_ovp_ctrl_tb

/* tb/vsp_far_end.sv */
`timescale 1ns/1ps
// ==========================================================
// Far side: enable pin driver, switching clock, plain load
module vsp_far_end (
   input wire logic clk,
   input wire logic pin_drive,
   input wire logic pin_val,
   input wire logic [15:0] bump,
   input wire logic out_enable,
   input wire logic [15:0] vout_target,
   output logic ctrl_pin_level,
   output logic ctrl_pin_driven,
   output logic pwm_clk_pin,
   output logic [15:0] vout_meas
);
   // ==========================================================
   // Switching clock
   // Fixed period from time zero, so it is steady before any enable
   initial begin
      pwm_clk_pin = 1'b0;
      #7;
      forever #80 pwm_clk_pin = ~pwm_clk_pin;
   end

   // ==========================================================
   // Enable pin and load
   // Released pin sits at the pull-up level
   assign ctrl_pin_driven = pin_drive;
   assign ctrl_pin_level = pin_drive ? pin_val : 1'b1;

   // Load follows the target; bump forces an over-voltage on request
   initial vout_meas = 16'h0000;
   always @(posedge clk) begin
      vout_meas <= out_enable ? vout_target + bump : 16'h0000;
   end
endmodule // vsp_far_end
